/* File: mgmt_ctrl_defines.vh */
`ifndef MGMT_CTRL_DEFINES_VH
`define MGMT_CTRL_DEFINES_VH

// Fixed upper nibble of the management bus address byte.
`define MGMT_ADDR_FIXED 4'h5

// Register offsets on the management bus.
`define REG_CTRL 8'h00
`define REG_CHDIS_LO 8'h01
`define REG_CHDIS_HI 8'h02
`define REG_STATUS 8'h03

// Field positions.
`define CTRL_PULSE_BIT 0
`define STATUS_FAULT_BIT 0
`define STATUS_LOS_BIT 1
`define STATUS_MON_BIT 2
`define STATUS_PEND_BIT 3

// Reset values.
`define CTRL_RESET 8'h00
`define CHDIS_RESET 12'h000
`define TXDIS_ALL 12'hFFF

// Timing.
`define CLK_FREQ_MHZ 50
`define IRQ_PULSE_NS 1000
`define IRQ_PULSE_CYCLES ((`IRQ_PULSE_NS * `CLK_FREQ_MHZ + 999) / 1000)

`endif

/* File: pin_sync.v */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk,
  input wire srst,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] stage1;

  // Only the second stage is visible outside, so nothing can read a metastable value.
  always @(posedge clk) begin
    if (srst) begin
      stage1 <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule // pin_sync

`default_nettype wire

/* File: module_mgmt_control.v */
// How it works
// - Address byte is fixed 0101, then three strap bits, then read/write bit.
// - Straps 2,1,0 land on byte bits 3,2,1; respond only on a match.
// - Lowest address bit 0 means write, 1 means read.
// - Unconnected strap inputs read as zero through the weak pull-down.
// - Any fault, loss of signal or monitor flag setting raises the interrupt.
// - Interrupt is pulse or held level by bus setting; level after defaults.
// - Interrupt pin floats when idle and drives low only when asserted.
// - Module reset held low keeps every optical channel output disabled.
// - Module reset held low makes the device ignore all bus commands.
// - Module reset restores every configurable setting to its default.
// - An open reset input counts as deasserted through the internal pull-up.
`include "mgmt_ctrl_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module module_mgmt_control (
  input wire clk,
  input wire srst,
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire moduleResetN,
  input wire [2:0] addrStrap,
  input wire [11:0] faultFlags,
  input wire [11:0] losFlags,
  input wire [7:0] monitorFlags,
  output reg hostIrqNOut,
  output reg hostIrqNOe,
  output reg [11:0] txDisable
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_ADDR = 6'h02;
  localparam [5:0] S_ACK = 6'h04;
  localparam [5:0] S_WR = 6'h08;
  localparam [5:0] S_RD = 6'h10;
  localparam [5:0] S_RACK = 6'h20;
  localparam integer PULSE_INT = `IRQ_PULSE_CYCLES;
  localparam [7:0] PULSE_LOAD = PULSE_INT[7:0];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  wire sclS;
  wire sdaS;
  wire resetPinS;
  wire [2:0] strapS;

  pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_scl (
    .clk(clk), .srst(srst), .d(sclIn), .q(sclS)
  );
  pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_sda (
    .clk(clk), .srst(srst), .d(sdaIn), .q(sdaS)
  );
  // The pad pull-up makes an open reset pin arrive as high; the flops start deasserted too.
  pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_sync_rst (
    .clk(clk), .srst(srst), .d(moduleResetN), .q(resetPinS)
  );
  // The pad pull-down makes open straps arrive as zero; the flops start at zero too.
  pin_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync_strap (
    .clk(clk), .srst(srst), .d(addrStrap), .q(strapS)
  );

  reg sclD;
  reg sdaD;
  reg resetPinD;

  always @(posedge clk) begin
    if (srst) begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
      resetPinD <= 1'b1;
    end else begin
      sclD <= sclS;
      sdaD <= sdaS;
      resetPinD <= resetPinS;
    end
  end

  wire sclRise = sclS & ~sclD;
  wire sclFall = ~sclS & sclD;
  wire startCond = sclS & sclD & sdaD & ~sdaS;
  wire stopCond = sclS & sclD & ~sdaD & sdaS;
  wire modRst = ~resetPinS;
  wire rstRelease = resetPinS & ~resetPinD;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt causes.

  wire [31:0] allFlags = {monitorFlags, losFlags, faultFlags};
  reg [31:0] flagsD;
  wire anyCause = |allFlags;
  wire newEvent = |(allFlags & ~flagsD);

  reg [7:0] ctrlReg;
  reg [11:0] chDis;
  reg pending;
  reg clrPending;
  reg [7:0] pulseCnt;

  //////////////////////////////////////////////////////////////////////////////
  // Register access helpers.

  function addrMatch;
    input [6:0] upper;
    input [2:0] strap;
    begin
      addrMatch = (upper == {`MGMT_ADDR_FIXED, strap});
    end
  endfunction

  function [7:0] regRead;
    input [7:0] a;
    begin
      case (a)
        `REG_CTRL: regRead = ctrlReg;
        `REG_CHDIS_LO: regRead = chDis[7:0];
        `REG_CHDIS_HI: regRead = {4'h0, chDis[11:8]};
        `REG_STATUS: regRead = {4'h0, pending, |monitorFlags, |losFlags, |faultFlags};
        default: regRead = 8'h00;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Two-wire management bus slave.

  reg [5:0] state;
  reg [7:0] shiftReg;
  reg [3:0] bitCnt;
  reg rwBit;
  reg ptrPhase;
  reg [7:0] ptr;
  // The read byte is decoded from the current pointer, so it is ready at the load edge.
  wire [7:0] rdNow = regRead(ptr);

  always @(posedge clk) begin
    if (srst) begin
      state <= S_IDLE;
      shiftReg <= 8'h00;
      bitCnt <= 4'h0;
      rwBit <= 1'b0;
      ptrPhase <= 1'b0;
      ptr <= 8'h00;
      sdaOe <= 1'b0;
      ctrlReg <= `CTRL_RESET;
      chDis <= `CHDIS_RESET;
      clrPending <= 1'b0;
    end else if (modRst) begin
      state <= S_IDLE;
      sdaOe <= 1'b0;
      ctrlReg <= `CTRL_RESET;
      chDis <= `CHDIS_RESET;
      ptr <= 8'h00;
      clrPending <= 1'b0;
    end else begin
      clrPending <= 1'b0;
      if (startCond) begin
        state <= S_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state <= S_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          S_IDLE: begin
            sdaOe <= 1'b0;
          end
          S_ADDR, S_WR: begin
            if (sclRise && bitCnt != 4'h8) begin
              shiftReg <= {shiftReg[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              if (state == S_ADDR) begin
                if (addrMatch(shiftReg[7:1], strapS)) begin
                  rwBit <= shiftReg[0];
                  ptrPhase <= ~shiftReg[0];
                  sdaOe <= 1'b1;
                  state <= S_ACK;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                if (ptrPhase) begin
                  ptr <= shiftReg;
                  ptrPhase <= 1'b0;
                end else begin
                  case (ptr)
                    `REG_CTRL: ctrlReg <= shiftReg;
                    `REG_CHDIS_LO: chDis[7:0] <= shiftReg;
                    `REG_CHDIS_HI: chDis[11:8] <= shiftReg[3:0];
                    default: ;
                  endcase
                  ptr <= ptr + 8'h01;
                end
                sdaOe <= 1'b1;
                state <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              bitCnt <= 4'h0;
              if (rwBit) begin
                shiftReg <= rdNow;
                sdaOe <= ~rdNow[7];
                clrPending <= (ptr == `REG_STATUS);
                state <= S_RD;
              end else begin
                sdaOe <= 1'b0;
                state <= S_WR;
              end
            end
          end
          S_RD: begin
            if (sclFall) begin
              if (bitCnt == 4'h7) begin
                sdaOe <= 1'b0;
                state <= S_RACK;
              end else begin
                sdaOe <= ~shiftReg[6];
                shiftReg <= {shiftReg[6:0], 1'b0};
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              if (sdaS) begin
                state <= S_IDLE;
              end else begin
                ptr <= ptr + 8'h01;
                state <= S_ACK;
              end
            end
          end
          default: begin
            state <= S_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt generation and channel disable.

  wire pulseMode = ctrlReg[`CTRL_PULSE_BIT];
  wire irqAssert = pulseMode ? (pulseCnt != 8'h00) : pending;

  always @(posedge clk) begin
    if (srst) begin
      flagsD <= 32'h0000_0000;
      pending <= 1'b0;
      pulseCnt <= 8'h00;
      hostIrqNOut <= 1'b0;
      sdaOut <= 1'b0;
      hostIrqNOe <= 1'b0;
      txDisable <= `TXDIS_ALL;
    end else begin
      flagsD <= allFlags;
      hostIrqNOut <= 1'b0;
      sdaOut <= 1'b0;
      if (modRst) begin
        pending <= 1'b0;
        pulseCnt <= 8'h00;
        hostIrqNOe <= 1'b0;
        txDisable <= `TXDIS_ALL;
      end else begin
        txDisable <= chDis;
        // A cause still standing at release is raised again; one that vanished stays clear.
        if (rstRelease) begin
          pending <= anyCause;
          pulseCnt <= anyCause ? PULSE_LOAD : 8'h00;
        end else begin
          // A new event in the cycle of a status read keeps the interrupt pending.
          pending <= newEvent | (pending & ~clrPending);
          if (newEvent) begin
            pulseCnt <= PULSE_LOAD;
          end else if (pulseCnt != 8'h00) begin
            pulseCnt <= pulseCnt - 8'h01;
          end
        end
        hostIrqNOe <= irqAssert;
      end
    end
  end

endmodule // module_mgmt_control

`default_nettype wire

/* File: module_mgmt_control_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module module_mgmt_control_checker (
  input wire clk,
  input wire srst,
  input wire sdaOut,
  input wire sdaOe,
  input wire moduleResetN,
  input wire [11:0] faultFlags,
  input wire [11:0] losFlags,
  input wire [7:0] monitorFlags,
  input wire hostIrqNOut,
  input wire hostIrqNOe,
  input wire [11:0] txDisable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  pins_od_a: assert property (sdaOut == 1'b0 && hostIrqNOut == 1'b0)
    else $error("pin driven high");
  rst_dflt_a: assert property (
    $fell(srst) |-> txDisable == 12'hFFF && !sdaOe && !hostIrqNOe)
    else $error("bad reset state");
  // The module reset pin passes a two-flop synchronizer, hence the run-in counts.
  mrst_txdis_a: assert property (!moduleResetN [*4] |-> txDisable == 12'hFFF)
    else $error("channel enabled in reset");
  mrst_ack_a: assert property (!moduleResetN [*4] |-> !sdaOe)
    else $error("bus answered in reset");
  mrst_irq_a: assert property (!moduleResetN [*5] |-> !hostIrqNOe)
    else $error("interrupt kept in reset");
  irq_cause_a: assert property (
    moduleResetN [*4] ##0 ((faultFlags & ~$past(faultFlags)) != 12'h000
    || (losFlags & ~$past(losFlags)) != 12'h000
    || (monitorFlags & ~$past(monitorFlags)) != 8'h00) |-> ##[1:3] hostIrqNOe)
    else $error("event gave no interrupt");
  irq_hold_a: assert property ($rose(hostIrqNOe) |=> hostIrqNOe [*8])
    else $error("interrupt too short");
  ack_hold_a: assert property ($rose(sdaOe) |=> sdaOe [*6])
    else $error("data drive too short");
  cover property ($rose(hostIrqNOe));
  cover property ($rose(sdaOe));
  cover property ($fell(moduleResetN));
endmodule // module_mgmt_control_checker
bind module_mgmt_control module_mgmt_control_checker module_mgmt_control_checker_inst (
  .clk, .srst, .sdaOut, .sdaOe, .moduleResetN, .faultFlags, .losFlags, .monitorFlags,
  .hostIrqNOut, .hostIrqNOe, .txDisable);
`default_nettype wire

/* File: mgmt_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  // Only the bus pins are modelled, so no high-speed lane is ever driven early.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // Data moves mid-way through the low phase so it never races the clock edge.
  task automatic bitx(input logic b, output logic r);
    sdaLow = !b;
    #40 scl = 1'b1;
    #80 r = sda;
    scl = 1'b0;
    #40;
  endtask
  task automatic start();
    sdaLow = 1'b1;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #40 scl = 1'b1;
    #40 sdaLow = 1'b0;
    #40;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
      output logic ao);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], q[i]);
    bitx(ak, ao);
  endtask
endmodule // mgmt_host
`default_nettype wire

/* File: tb_module_mgmt_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_module_mgmt_control;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic moduleResetN = 1'b1;
  logic [2:0] addrStrap = 3'h5;
  logic [11:0] faultFlags = 12'h000;
  logic [11:0] losFlags = 12'h000;
  logic [7:0] monitorFlags = 8'h00;
  logic [7:0] q;
  logic [7:0] q2;
  logic a;
  integer mismatches = 0;
  integer n_compared = 0;
  wire scl, sdaLow, sdaOut, sdaOe, hostIrqNOut, hostIrqNOe;
  wire [11:0] txDisable;
  // The line is pulled up, so it is low while either party pulls it.
  wire sda = ~(sdaLow | sdaOe);
  always #10 clk = ~clk;
  mgmt_host mgmt_host_inst (.scl(scl), .sdaLow(sdaLow), .sda(sda));
  module_mgmt_control module_mgmt_control_inst (.clk(clk), .srst(srst), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .moduleResetN(moduleResetN),
    .addrStrap(addrStrap), .faultFlags(faultFlags), .losFlags(losFlags),
    .monitorFlags(monitorFlags), .hostIrqNOut(hostIrqNOut), .hostIrqNOe(hostIrqNOe),
    .txDisable(txDisable));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic sendAddr(input logic [2:0] st, input logic rw, output logic ack);
    logic [7:0] d;
    mgmt_host_inst.start();
    mgmt_host_inst.xfer({4'h5, st, rw}, 1'b1, d, ack);
  endtask
  task automatic busWrite(input logic [2:0] st, input logic [7:0] p, input logic [7:0] v,
      output logic ack);
    logic [7:0] d;
    logic x;
    sendAddr(st, 1'b0, ack);
    if (ack === 1'b0) begin
      mgmt_host_inst.xfer(p, 1'b1, d, x);
      mgmt_host_inst.xfer(v, 1'b1, d, x);
    end
    mgmt_host_inst.stop();
  endtask
  // Only the pointer is written, so setting it never writes the register that the read then looks at.
  task automatic setPtr(input logic [7:0] p);
    logic [7:0] d;
    logic x;
    sendAddr(3'h5, 1'b0, x);
    mgmt_host_inst.xfer(p, 1'b1, d, x);
    mgmt_host_inst.stop();
  endtask
  task automatic busRead(input logic [7:0] p, output logic [7:0] v);
    logic x;
    setPtr(p);
    sendAddr(3'h5, 1'b1, x);
    mgmt_host_inst.xfer(8'hFF, 1'b1, v, x);
    mgmt_host_inst.stop();
  endtask
  // The host acknowledges the first byte, so the pointer must step to the next register.
  task automatic busReadPair(input logic [7:0] p, output logic [7:0] v0,
      output logic [7:0] v1);
    logic x;
    setPtr(p);
    sendAddr(3'h5, 1'b1, x);
    mgmt_host_inst.xfer(8'hFF, 1'b0, v0, x);
    mgmt_host_inst.xfer(8'hFF, 1'b1, v1, x);
    mgmt_host_inst.stop();
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (6) @(negedge clk);
    busWrite(3'h5, 8'h01, 8'hA5, a);
    check(12'(a), 12'h000);
    check(txDisable, 12'h0A5);
    for (int i = 0; i < 8; i++)
      if (i != 5) begin
        busWrite(3'(i), 8'h01, 8'h00, a);
        check(12'(a), 12'h001);
      end
    busRead(8'h01, q);
    check(12'(q), 12'h0A5);
    busReadPair(8'h00, q, q2);
    check(12'(q), 12'h000);
    check(12'(q2), 12'h0A5);
    faultFlags[3] = 1'b1;
    repeat (3) @(negedge clk);
    check(12'(hostIrqNOe), 12'h001);
    repeat (100) @(negedge clk);
    check(12'(hostIrqNOe), 12'h001);
    busRead(8'h03, q);
    check(12'(q), 12'h009);
    check(12'(hostIrqNOe), 12'h000);
    busWrite(3'h5, 8'h00, 8'h01, a);
    for (int k = 0; k < 3; k++) begin
      if (k == 0)
        faultFlags[0] = 1'b1;
      else if (k == 1)
        losFlags[0] = 1'b1;
      else
        monitorFlags[7] = 1'b1;
      repeat (3) @(negedge clk);
      check(12'(hostIrqNOe), 12'h001);
      repeat (52) @(negedge clk);
      check(12'(hostIrqNOe), 12'h000);
    end
    // Straps left open read as zero, so the all-zero address must answer.
    addrStrap = 3'h0;
    repeat (4) @(negedge clk);
    busWrite(3'h0, 8'h02, 8'h00, a);
    check(12'(a), 12'h000);
    addrStrap = 3'h5;
    moduleResetN = 1'b0;
    repeat (6) @(negedge clk);
    check(txDisable, 12'hFFF);
    busWrite(3'h5, 8'h01, 8'h00, a);
    check(12'(a), 12'h001);
    faultFlags = 12'h000;
    losFlags = 12'h000;
    monitorFlags = 8'h00;
    moduleResetN = 1'b1;
    repeat (6) @(negedge clk);
    check(txDisable, 12'h000);
    check(12'(hostIrqNOe), 12'h000);
    busRead(8'h01, q);
    check(12'(q), 12'h000);
    faultFlags[5] = 1'b1;
    repeat (60) @(negedge clk);
    check(12'(hostIrqNOe), 12'h001);
    print_verdict();
  end
endmodule // tb_module_mgmt_control
`default_nettype wire
